// ### src/sfft_regs.vh
// constants for the flag-timing fifo: geometry, register map, timing
`ifndef SFFT_REGS_VH
`define SFFT_REGS_VH

// geometry
`define SFFT_WIDTH          9
`define SFFT_DEPTH          64
`define SFFT_AW             6
`define SFFT_CW             7
`define SFFT_DEPTH_CNT      7'h40

// register byte addresses
`define SFFT_ADDR_AE_OFFSET 4'h0
`define SFFT_ADDR_AF_OFFSET 4'h4
`define SFFT_ADDR_STATUS    4'h8

// register reset values
`define SFFT_AE_OFFSET_RST  7'h07
`define SFFT_AF_OFFSET_RST  7'h07

// status field positions
`define SFFT_ST_COUNT_LSB   0
`define SFFT_ST_EMPTY_N     8
`define SFFT_ST_FULL_N      9
`define SFFT_ST_AEMPTY_N    10
`define SFFT_ST_AFULL_N     11
`define SFFT_ST_SECOND_EN   12

// axi responses
`define SFFT_RESP_OKAY      2'h0
`define SFFT_RESP_SLVERR    2'h2

// timing
`define SFFT_CLOCK_PERIOD_NS     10
`define SFFT_SKEW_PRIMARY_NS     5
`define SFFT_SKEW_SECONDARY_NS   15
`define SFFT_SKEW_PRIMARY_CYC    \
    ((`SFFT_SKEW_PRIMARY_NS + `SFFT_CLOCK_PERIOD_NS - 1) / `SFFT_CLOCK_PERIOD_NS)
`define SFFT_SKEW_SECONDARY_CYC  \
    ((`SFFT_SKEW_SECONDARY_NS + `SFFT_CLOCK_PERIOD_NS - 1) / `SFFT_CLOCK_PERIOD_NS)

`endif

// ### src/sfft_fifo.v
// parameterised storage fifo with valid/ready on both sides
`timescale 1ns/1ps
module sfft_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 64,
    parameter AW    = 6
) (
    // clock and reset
    input  wire             aclk,
    input  wire             aresetn,
    // fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data,
    // occupancy
    output wire [AW:0]      count
);

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0]    wr_ptr_reg;
reg [AW-1:0]    rd_ptr_reg;
reg [AW:0]      count_reg;
wire            push;
wire            pop;

////////////////////////////////////////////////////////////////////////////////
assign in_ready  = (count_reg != DEPTH[AW:0]);
assign out_valid = (count_reg != {(AW+1){1'b0}});
assign push      = in_valid & in_ready;
assign pop       = out_valid & out_ready;
assign out_data  = mem[rd_ptr_reg];
assign count     = count_reg;

always @(posedge aclk) begin
    if (push) begin
        mem[wr_ptr_reg] <= in_data;
    end
end

// pointers wrap naturally since depth is a power of two
always @(posedge aclk) begin
    if (!aresetn) begin
        wr_ptr_reg <= {AW{1'b0}};
        rd_ptr_reg <= {AW{1'b0}};
        count_reg  <= {(AW+1){1'b0}};
    end else begin
        if (push) begin
            wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
        end
        if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
        end
        if (push && !pop) begin
            count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
        end else if (pop && !push) begin
            count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
        end
    end
end

endmodule

// ### src/sfft_top.v
// synchronous fifo with active-low flags, offset registers and axi4-lite access
//
// Summary of operation
// - full flag releases one clock after the freeing read, never the same edge.
// - empty flag releases one clock after the first write, never the same edge.
// - clocks keep running through reset; nothing needs the clock stopped.
// - write-enable/load pin level during reset picks second enable or load role.
// - after reset data outputs are low when enabled, released when disabled.
// - first word appears on outputs the cycle after empty flag rises.
// - first-word latency at empty boundary is one or two clock periods.
// - almost-empty flag releases one clock late, which covers the primary skew but not the secondary.
// - read leaving offset minus one words drives almost-empty flag low.
// - write reaching depth minus offset plus one drives almost-full low.
// - almost-full flag releases one clock late, which covers the primary skew but not the secondary.
// - almost-full threshold is storage depth minus the almost-full offset.
// - primary skew minimum is five, six or ten nanoseconds by grade.
// - secondary skew minimum is fifteen or eighteen nanoseconds by grade.
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "sfft_regs.vh"
module sfft_top (
    // clock and reset
    input  wire                   aclk,
    input  wire                   aresetn,
    // axi4-lite write address
    input  wire                   s_axi_awvalid,
    output wire                   s_axi_awready,
    input  wire [3:0]             s_axi_awaddr,
    // axi4-lite write data
    input  wire                   s_axi_wvalid,
    output wire                   s_axi_wready,
    input  wire [31:0]            s_axi_wdata,
    input  wire [3:0]             s_axi_wstrb,
    // axi4-lite write response
    output wire                   s_axi_bvalid,
    input  wire                   s_axi_bready,
    output wire [1:0]             s_axi_bresp,
    // axi4-lite read address
    input  wire                   s_axi_arvalid,
    output wire                   s_axi_arready,
    input  wire [3:0]             s_axi_araddr,
    // axi4-lite read data
    output wire                   s_axi_rvalid,
    input  wire                   s_axi_rready,
    output wire [31:0]            s_axi_rdata,
    output wire [1:0]             s_axi_rresp,
    // write port
    input  wire                   write_enable_primary_n,
    input  wire                   write_enable_or_offset_load,
    input  wire [`SFFT_WIDTH-1:0] data_in,
    // read port
    input  wire                   read_enable_primary_n,
    input  wire                   read_enable_secondary_n,
    input  wire                   output_enable_n,
    output wire [`SFFT_WIDTH-1:0] data_out,
    output wire                   data_out_oe_n,
    // flags
    output wire                   empty_flag_n,
    output wire                   full_flag_n,
    output wire                   almost_empty_flag_n,
    output wire                   almost_full_flag_n
);

reg                    second_enable_mode_reg;
reg                    load_sel_reg;
reg  [`SFFT_CW-1:0]    ae_offset_reg;
reg  [`SFFT_CW-1:0]    af_offset_reg;
reg                    empty_n_reg;
reg                    full_n_reg;
reg                    aempty_n_reg;
reg                    afull_n_reg;
reg                    empty_n_next;
reg                    full_n_next;
reg                    aempty_n_next;
reg                    afull_n_next;
reg  [`SFFT_WIDTH-1:0] data_out_reg;
reg                    oe_n_reg;
reg                    aw_held_reg;
reg  [3:0]             aw_addr_reg;
reg                    w_held_reg;
reg  [31:0]            w_data_reg;
reg  [3:0]             w_strb_reg;
reg                    bvalid_reg;
reg  [1:0]             bresp_reg;
reg                    rvalid_reg;
reg  [31:0]            rdata_reg;
reg  [1:0]             rresp_reg;
reg  [31:0]            rdata_next;
reg  [1:0]             rresp_next;
wire                   fifo_in_ready;
wire                   fifo_out_valid;
wire [`SFFT_WIDTH-1:0] fifo_out_data;
wire [`SFFT_CW-1:0]    count;
wire                   write_req;
wire                   load_req;
wire                   write_fire;
wire                   read_fire;
wire [`SFFT_CW-1:0]    count_after;
wire [`SFFT_CW-1:0]    af_threshold;
wire                   reg_write;
wire [31:0]            status_word;

////////////////////////////////////////////////////////////////////////////////
// port qualification

// load cycles never reach storage
assign write_req  = !write_enable_primary_n & write_enable_or_offset_load;
assign load_req   = !write_enable_primary_n & !write_enable_or_offset_load
                    & !second_enable_mode_reg;
assign write_fire = write_req & full_n_reg & fifo_in_ready;
assign read_fire  = !read_enable_primary_n & !read_enable_secondary_n
                    & empty_n_reg & fifo_out_valid;

sfft_fifo #(
    .WIDTH (`SFFT_WIDTH),
    .DEPTH (`SFFT_DEPTH),
    .AW    (`SFFT_AW)
) sfft_fifo_i (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (write_fire),
    .in_ready  (fifo_in_ready),
    .in_data   (data_in),
    .out_valid (fifo_out_valid),
    .out_ready (read_fire),
    .out_data  (fifo_out_data),
    .count     (count)
);

////////////////////////////////////////////////////////////////////////////////
// role of the dual-purpose pin, caught while reset is held

// sampled on every clock of reset, so a running clock is fine
always @(posedge aclk) begin
    if (!aresetn) begin
        second_enable_mode_reg <= write_enable_or_offset_load;
    end
end

////////////////////////////////////////////////////////////////////////////////
// flags

assign count_after  = count + {{(`SFFT_CW-1){1'b0}}, write_fire}
                            - {{(`SFFT_CW-1){1'b0}}, read_fire};
assign af_threshold = `SFFT_DEPTH_CNT - af_offset_reg;

// assertion is immediate, release waits for the stored count to settle:
// a fixed one-clock lag covers the primary skew minimum; the secondary one needs two clocks at this rate
always @* begin
    empty_n_next  = 1'b0;
    full_n_next   = 1'b0;
    aempty_n_next = 1'b0;
    afull_n_next  = 1'b0;
    if (count_after != {`SFFT_CW{1'b0}}) begin
        empty_n_next = (count != {`SFFT_CW{1'b0}});
    end
    if (count_after != `SFFT_DEPTH_CNT) begin
        full_n_next = (count != `SFFT_DEPTH_CNT);
    end
    if (count_after >= ae_offset_reg) begin
        aempty_n_next = (count >= ae_offset_reg);
    end
    if (count_after <= af_threshold) begin
        afull_n_next = (count <= af_threshold);
    end
end

always @(posedge aclk) begin
    if (!aresetn) begin
        empty_n_reg  <= 1'b0;
        full_n_reg   <= 1'b1;
        aempty_n_reg <= 1'b0;
        afull_n_reg  <= 1'b1;
    end else begin
        empty_n_reg  <= empty_n_next;
        full_n_reg   <= full_n_next;
        aempty_n_reg <= aempty_n_next;
        afull_n_reg  <= afull_n_next;
    end
end

assign empty_flag_n        = empty_n_reg;
assign full_flag_n         = full_n_reg;
assign almost_empty_flag_n = aempty_n_reg;
assign almost_full_flag_n  = afull_n_reg;

////////////////////////////////////////////////////////////////////////////////
// read data path

// reads gated by the registered empty flag, so the first word leaves
// exactly one clock after the flag rises
always @(posedge aclk) begin
    if (!aresetn) begin
        data_out_reg <= {`SFFT_WIDTH{1'b0}};
        oe_n_reg     <= 1'b1;
    end else begin
        oe_n_reg <= output_enable_n;
        if (read_fire) begin
            data_out_reg <= fifo_out_data;
        end
    end
end

assign data_out      = data_out_reg;
assign data_out_oe_n = oe_n_reg;

////////////////////////////////////////////////////////////////////////////////
// axi4-lite slave

assign s_axi_awready = !aw_held_reg;
assign s_axi_wready  = !w_held_reg;
assign s_axi_bvalid  = bvalid_reg;
assign s_axi_bresp   = bresp_reg;
assign s_axi_arready = !rvalid_reg;
assign s_axi_rvalid  = rvalid_reg;
assign s_axi_rdata   = rdata_reg;
assign s_axi_rresp   = rresp_reg;
assign reg_write     = aw_held_reg & w_held_reg & !bvalid_reg;

always @(posedge aclk) begin
    if (!aresetn) begin
        aw_held_reg <= 1'b0;
        aw_addr_reg <= 4'h0;
        w_held_reg  <= 1'b0;
        w_data_reg  <= 32'h0000_0000;
        w_strb_reg  <= 4'h0;
        bvalid_reg  <= 1'b0;
        bresp_reg   <= `SFFT_RESP_OKAY;
    end else begin
        if (s_axi_awvalid && !aw_held_reg) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held_reg) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end
        if (reg_write) begin
            bvalid_reg  <= 1'b1;
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            if (aw_addr_reg == `SFFT_ADDR_AE_OFFSET || aw_addr_reg == `SFFT_ADDR_AF_OFFSET) begin
                bresp_reg <= `SFFT_RESP_OKAY;
            end else begin
                bresp_reg <= `SFFT_RESP_SLVERR;
            end
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end
end

// offsets: bus write wins over a pin load in the same cycle
always @(posedge aclk) begin
    if (!aresetn) begin
        ae_offset_reg <= `SFFT_AE_OFFSET_RST;
        af_offset_reg <= `SFFT_AF_OFFSET_RST;
        load_sel_reg  <= 1'b0;
    end else if (reg_write && w_strb_reg[0]) begin
        if (aw_addr_reg == `SFFT_ADDR_AE_OFFSET) begin
            ae_offset_reg <= w_data_reg[`SFFT_CW-1:0];
        end else if (aw_addr_reg == `SFFT_ADDR_AF_OFFSET) begin
            af_offset_reg <= w_data_reg[`SFFT_CW-1:0];
        end
    end else if (load_req) begin
        // alternate loads: almost-empty offset first, then almost-full
        load_sel_reg <= !load_sel_reg;
        if (load_sel_reg) begin
            af_offset_reg <= data_in[`SFFT_CW-1:0];
        end else begin
            ae_offset_reg <= data_in[`SFFT_CW-1:0];
        end
    end
end

assign status_word = {19'h0_0000,
                      second_enable_mode_reg,
                      afull_n_reg,
                      aempty_n_reg,
                      full_n_reg,
                      empty_n_reg,
                      1'b0,
                      count};

always @* begin
    rdata_next = 32'h0000_0000;
    rresp_next = `SFFT_RESP_OKAY;
    case (s_axi_araddr)
        `SFFT_ADDR_AE_OFFSET: begin
            rdata_next = {25'h000_0000, ae_offset_reg};
        end
        `SFFT_ADDR_AF_OFFSET: begin
            rdata_next = {25'h000_0000, af_offset_reg};
        end
        `SFFT_ADDR_STATUS: begin
            rdata_next = status_word;
        end
        default: begin
            rresp_next = `SFFT_RESP_SLVERR;
        end
    endcase
end

always @(posedge aclk) begin
    if (!aresetn) begin
        rvalid_reg <= 1'b0;
        rdata_reg  <= 32'h0000_0000;
        rresp_reg  <= `SFFT_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_reg) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rdata_next;
        rresp_reg  <= rresp_next;
    end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
    end
end

endmodule

// ### verification/sfft_chk.sv
// port checks for the flag-timing fifo
`timescale 1ns/1ps
`include "sfft_regs.vh"
module sfft_chk (
    // clock and reset
    input wire                   aclk,
    input wire                   aresetn,
    // port enables
    input wire                   write_enable_primary_n,
    input wire                   write_enable_or_offset_load,
    input wire                   read_enable_primary_n,
    input wire                   read_enable_secondary_n,
    input wire                   output_enable_n,
    // outputs
    input wire [`SFFT_WIDTH-1:0] data_out,
    input wire                   data_out_oe_n,
    input wire                   empty_flag_n,
    input wire                   full_flag_n,
    input wire                   almost_empty_flag_n,
    input wire                   almost_full_flag_n
);
////////////////////////////////////////////////////////////
    wire wr = !write_enable_primary_n && write_enable_or_offset_load;
    wire rd = !read_enable_primary_n && !read_enable_secondary_n && empty_flag_n;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // a prior write may already be releasing the flag, so only the first counts
    a_empty_late: assert property (!empty_flag_n && wr && !$past(wr)
        |=> !empty_flag_n ##1 empty_flag_n) else $error("empty flag release off");
    a_full_late: assert property (!full_flag_n && rd && !$past(rd)
        |=> !full_flag_n ##1 full_flag_n) else $error("full flag release off");
    a_aempty_cause: assert property ($rose(almost_empty_flag_n)
        |-> $past(wr, 2)) else $error("almost empty rose without write");
    a_afull_cause: assert property ($rose(almost_full_flag_n)
        |-> $past(rd, 2)) else $error("almost full rose without read");
    a_data_hold: assert property (!empty_flag_n
        |=> $stable(data_out)) else $error("read while empty");
    a_reset_out: assert property ($rose(aresetn)
        |-> data_out == 0 && data_out_oe_n ##1 data_out_oe_n == $past(output_enable_n))
        else $error("output state after reset wrong");
    a_full_holds: assert property (!full_flag_n && !rd && !$past(rd)
        |=> !full_flag_n) else $error("full flag dropped");
    a_empty_holds: assert property (!empty_flag_n && !wr && !$past(wr)
        |=> !empty_flag_n) else $error("empty flag dropped");
    c_empty_rise: cover property ($rose(empty_flag_n));
    c_full_fall: cover property ($fell(full_flag_n));
    c_afull_fall: cover property ($fell(almost_full_flag_n));
endmodule
bind sfft_top sfft_chk sfft_chk_i (
    .aclk, .aresetn, .write_enable_primary_n, .write_enable_or_offset_load,
    .read_enable_primary_n, .read_enable_secondary_n, .output_enable_n, .data_out,
    .data_out_oe_n, .empty_flag_n, .full_flag_n, .almost_empty_flag_n, .almost_full_flag_n
);

// ### verification/sfft_partner.sv
// producer and consumer model on the two fifo ports
`timescale 1ns/1ps
`include "sfft_regs.vh"
module sfft_partner (
    // clock
    input wire                   aclk,
    // bench controls
    input wire                   wr_go,
    input wire                   rd_go,
    input wire                   rd_slow,
    // fifo side
    input wire                   full_flag_n,
    output reg                   wen_n = 1'b1,
    output reg [`SFFT_WIDTH-1:0] data = 9'h000,
    output reg                   ren_a_n = 1'b1,
    output reg                   ren_b_n = 1'b1
);
    reg [`SFFT_WIDTH-1:0] seq = 9'h001;
    always @(posedge aclk) begin
        // a refused word is held until the flag lets it in
        if (!wen_n && full_flag_n) seq = seq + 1;
        wen_n <= !wr_go;
        // junk between words so a stale value never passes
        data <= wr_go ? seq : ~seq;
        ren_a_n <= !rd_go;
        ren_b_n <= !(rd_go && (!rd_slow || ren_b_n));
    end
endmodule

// ### verification/sfft_bench.sv
// self-checking bench for the flag-timing fifo
`timescale 1ns/1ps
`include "sfft_regs.vh"
module sfft_bench;
    reg                   aclk = 1'b0, aresetn = 1'b0, pin = 1'b0, oe_n = 1'b0;
    reg                   wr_go = 1'b0, rd_go = 1'b0, rd_slow = 1'b0, pend = 1'b0, lp = 1'b0;
    reg                   awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    reg                   arvalid = 1'b0, rready = 1'b0;
    reg [3:0]             awaddr = 4'h0, araddr = 4'h0;
    reg [31:0]            wdata = 32'h0000_0000;
    reg [`SFFT_WIDTH-1:0] rexp;
    reg [`SFFT_WIDTH-1:0] q[$];
    wire                  awready, wready, bvalid, arready, rvalid;
    wire                  wen_n, ren_a, ren_b, oe_q_n, empty_n, full_n, aempty_n, afull_n;
    wire [1:0]            bresp, rresp;
    wire [31:0]           rdata;
    wire [`SFFT_WIDTH-1:0] din, dout;
    integer               n_fail = 0, compares = 0, c2 = 0, ae_off = 7, af_off = 7;
    localparam [1:0]      ok = `SFFT_RESP_OKAY, err = `SFFT_RESP_SLVERR;
////////////////////////////////////////////////////////////
    always #5 aclk = ~aclk;
    sfft_top sfft_top_i (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .write_enable_primary_n(wen_n), .write_enable_or_offset_load(pin),
        .data_in(din), .read_enable_primary_n(ren_a), .read_enable_secondary_n(ren_b),
        .output_enable_n(oe_n), .data_out(dout), .data_out_oe_n(oe_q_n),
        .empty_flag_n(empty_n), .full_flag_n(full_n),
        .almost_empty_flag_n(aempty_n), .almost_full_flag_n(afull_n)
    );
    sfft_partner sfft_partner_i (
        .aclk(aclk), .wr_go(wr_go), .rd_go(rd_go), .rd_slow(rd_slow),
        .full_flag_n(full_n), .wen_n(wen_n), .data(din), .ren_a_n(ren_a), .ren_b_n(ren_b)
    );
////////////////////////////////////////////////////////////
    task chk(input [31:0] got, input [31:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("BAD %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    // ready stays high after the answer: dropping it here would clash with
    // the next call raising it in the same time step; only the watchdog ends a wait
    task axi_wr(input [3:0] a, input [31:0] d, input [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        chk({bvalid, bresp}, {1'b1, er});
    endtask
    task axi_rd(input [3:0] a, input [31:0] d, input [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        chk({rvalid, rresp}, {1'b1, er});
        chk(rdata, d);
    endtask
    // one clock of both ports: flags judged against the bench's own count
    task step;
        integer c1;
        reg     w, r;
        @(posedge aclk);
        if (pend) chk(dout, rexp);
        c1 = q.size();
        chk(empty_n, c1 > 0 && c2 > 0);
        chk(full_n, c1 < `SFFT_DEPTH && c2 < `SFFT_DEPTH);
        chk(aempty_n, c1 >= ae_off && c2 >= ae_off);
        chk(afull_n, c1 <= `SFFT_DEPTH - af_off && c2 <= `SFFT_DEPTH - af_off);
        c2 = c1;
        w = !wen_n && pin && full_n;
        r = !ren_a && !ren_b && empty_n;
        pend = r;
        if (r) rexp = q.pop_front();
        if (w) q.push_back(din);
        if (!wen_n && !pin) begin
            if (lp) af_off = din[6:0];
            else ae_off = din[6:0];
            lp = !lp;
        end
    endtask
    task do_reset(input p);
        aresetn <= 1'b0;
        pin <= p;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        q.delete();
        c2 = 0;
        pend = 1'b0;
        lp = 1'b0;
        ae_off = 7;
        af_off = 7;
    endtask
////////////////////////////////////////////////////////////
    task t_load;
        axi_rd(`SFFT_ADDR_STATUS, 32'h0000_0a00, ok);
        wr_go <= 1'b1;
        step;
        step;
        wr_go <= 1'b0;
        repeat (3) step;
        axi_rd(`SFFT_ADDR_AE_OFFSET, ae_off, ok);
        axi_rd(`SFFT_ADDR_AF_OFFSET, af_off, ok);
    endtask
    task t_regs;
        axi_rd(`SFFT_ADDR_STATUS, 32'h0000_1a00, ok);
        axi_wr(`SFFT_ADDR_AE_OFFSET, 32'h0000_0005, ok);
        axi_wr(`SFFT_ADDR_AF_OFFSET, 32'h0000_0003, ok);
        ae_off = 5;
        af_off = 3;
        axi_rd(`SFFT_ADDR_AE_OFFSET, 32'h0000_0005, ok);
        axi_rd(`SFFT_ADDR_AF_OFFSET, 32'h0000_0003, ok);
        axi_wr(4'hc, 32'h0000_0001, err);
        axi_rd(4'hc, 32'h0000_0000, err);
    endtask
    // writer every cycle, reader pausing every other cycle
    task t_stream;
        wr_go <= 1'b1;
        rd_go <= 1'b1;
        rd_slow <= 1'b1;
        repeat (30) step;
        wr_go <= 1'b0;
        repeat (40) step;
    endtask
    // overfill, then drain past empty with reads still asked
    task t_fill_drain;
        rd_go <= 1'b0;
        wr_go <= 1'b1;
        repeat (72) step;
        wr_go <= 1'b0;
        rd_go <= 1'b1;
        rd_slow <= 1'b0;
        repeat (72) step;
        rd_go <= 1'b0;
    endtask
    task t_oe;
        oe_n <= 1'b1;
        step;
        step;
        chk(oe_q_n, 1'b1);
        oe_n <= 1'b0;
        step;
        step;
        chk(oe_q_n, 1'b0);
    endtask
    task report_and_stop;
        $display("fails %0d compares %0d", n_fail, compares);
        if (n_fail == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
////////////////////////////////////////////////////////////
    initial begin
        do_reset(1'b0);
        t_load;
        do_reset(1'b1);
        chk(dout, 9'h000);
        t_regs;
        t_stream;
        t_fill_drain;
        // mid-run reset with a word still on the outputs
        do_reset(1'b1);
        chk(dout, 9'h000);
        t_oe;
        report_and_stop;
    end
    initial begin
        #100000;
        n_fail = n_fail + 1;
        report_and_stop;
    end
endmodule
